// ==== common/ubf_pkg.sv ====
// shared constants and types for the byte fifo slave port
package ubf_pkg;
    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int PIN_W = 3;
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_OE = 2;
    localparam logic [PIN_W-1:0] PIN_IDLE = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    // ------------------------------------------------------------
    // mode and clocking
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_MODE_CODE = 8'h40;
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SYNC_CLK_HZ = 60_000_000;
    localparam int ACC_W = 28;
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * SYNC_CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_RESET = 28'h0000000;
    // ------------------------------------------------------------
    // flag recovery after an asynchronous cycle
    // ------------------------------------------------------------
    localparam int FLAG_HOLD_NS = 80;
    localparam int FLAG_HOLD_CYC = (FLAG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 4;
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(FLAG_HOLD_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;
    localparam logic [HOLD_W-1:0] HOLD_ONE = 4'h1;
    // ------------------------------------------------------------
    // strobe cycle phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_STROBE, PH_HOLD} ubf_phase_t;
endpackage : ubf_pkg

// ==== logic/ubf_fifo.sv ====
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module ubf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [CW-1:0] count_q, count_d;
    logic inReady_q, inReady_d, outValid_q, outValid_d;
    logic push, pop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        push = inValid && inReady_q;
        pop = outValid_q && outReady;
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        if (push) begin
            mem_d[wrPtr_q] = inData;
            wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
        end
        if (pop) begin
            rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
        end
        count_d = count_q + CW'(push) - CW'(pop);
        // flags registered so both handshakes leave from flops
        inReady_d = (count_d != CW'(DEPTH));
        outValid_d = (count_d != '0);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady_q <= 1'b1;
            outValid_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            inReady_q <= inReady_d;
            outValid_q <= outValid_d;
        end
    end

    assign inReady = inReady_q;
    assign outValid = outValid_q;
    assign outData = mem_q[rdPtr_q];
endmodule : ubf_fifo

// ==== logic/ubf_port.sv ====
// byte fifo slave port: async strobes and 60 MHz sync streaming
//
// Function
// - async: one byte moves per read or write strobe cycle on the 8-bit bus.
// - transmit buffer carries port writes to host; receive buffer carries host bytes out.
// - transmit-space flag low only while the transmit buffer has room.
// - receive-data flag low only while unread bytes remain in the receive buffer.
// - while receive-data flag is high the bus byte does not change.
// - async: flags pulse inactive briefly each cycle; a strobe while a flag is high moves no byte.
// - sync mode: device drives a 60 MHz clock that times all transfers.
// - sync mode only when mode setting equals 0x40, else asynchronous.
// - async: receive-data flag held inactive at least 80 ns after a read.
// - async: transmit-space flag held inactive at least 80 ns after a write.
`timescale 1ns/100ps
module ubf_port
    import ubf_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] bitMode,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe_n,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n,
    input wire logic outEnable_n,
    output logic rx_data_avail_n,
    output logic tx_space_flag_n,
    output logic sync_clock_out,
    input wire logic [DATA_W-1:0] hostRxData,
    input wire logic hostRxValid,
    output logic hostRxReady,
    output logic [DATA_W-1:0] hostTxData,
    output logic hostTxValid,
    input wire logic hostTxReady
);
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rstMeta_q, rstSync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    logic [PIN_W-1:0] pinS;
    logic [DATA_W-1:0] dataS;
    logic [7:0] modeS;

    ubf_sync2 #(.WIDTH(PIN_W), .RST_VAL(PIN_IDLE)) u_pinSync (
        .clk(mclk),
        .rstN(rstSync_n),
        .din({outEnable_n, wrStrobe_n, rdStrobe_n}),
        .dout(pinS)
    );

    // data rides the same two-stage delay as the strobes, so it lines up with them
    ubf_sync2 #(.WIDTH(DATA_W), .RST_VAL(DATA_RESET)) u_dataSync (
        .clk(mclk),
        .rstN(rstSync_n),
        .din(dataIn),
        .dout(dataS)
    );

    ubf_sync2 #(.WIDTH(8), .RST_VAL(8'h00)) u_modeSync (
        .clk(mclk),
        .rstN(rstSync_n),
        .din(bitMode),
        .dout(modeS)
    );

    logic rdS, wrS, oeS;
    assign rdS = pinS[PIN_RD];
    assign wrS = pinS[PIN_WR];
    assign oeS = pinS[PIN_OE];

    // ------------------------------------------------------------
    // buffers between host side and port
    // ------------------------------------------------------------
    logic rxPop, rxOutValid, txPush, txInReady;
    logic [DATA_W-1:0] rxHead, txPushData;

    // host bytes queue toward the port
    ubf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rxFifo (
        .clk(mclk),
        .rstN(rstSync_n),
        .inValid(hostRxValid),
        .inReady(hostRxReady),
        .inData(hostRxData),
        .outValid(rxOutValid),
        .outReady(rxPop),
        .outData(rxHead)
    );

    // port writes queue toward the host
    ubf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_txFifo (
        .clk(mclk),
        .rstN(rstSync_n),
        .inValid(txPush),
        .inReady(txInReady),
        .inData(txPushData),
        .outValid(hostTxValid),
        .outReady(hostTxReady),
        .outData(hostTxData)
    );

    // ------------------------------------------------------------
    // mode select and 60 MHz clock output
    // ------------------------------------------------------------
    logic syncMode_q, syncMode_d;
    logic [ACC_W-1:0] acc_q, acc_d, accSum;
    logic sync_clock_out_q, sync_clock_out_d, toggle, clkRise;
    logic rdPrev_q, wrPrev_q;

    // fractional divider: 60 MHz is no integer ratio of 125 MHz, so edges jitter by a cycle
    always_comb begin
        // sync behaviour only for the one mode code
        syncMode_d = (modeS == SYNC_MODE_CODE);
        accSum = acc_q + ACC_STEP;
        toggle = (accSum >= ACC_MOD);
        acc_d = toggle ? accSum - ACC_MOD : accSum;
        sync_clock_out_d = sync_clock_out_q ^ toggle;
        if (!syncMode_q) begin
            acc_d = ACC_RESET;
            sync_clock_out_d = 1'b0;
        end
        // transfers are timed by the rising edge of the driven clock
        clkRise = syncMode_q && toggle && !sync_clock_out_q;
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            syncMode_q <= 1'b0;
            acc_q <= ACC_RESET;
            sync_clock_out_q <= 1'b0;
            rdPrev_q <= 1'b1;
            wrPrev_q <= 1'b1;
        end else begin
            syncMode_q <= syncMode_d;
            acc_q <= acc_d;
            sync_clock_out_q <= sync_clock_out_d;
            rdPrev_q <= rdS;
            wrPrev_q <= wrS;
        end
    end

    logic rdFall, rdRise, wrFall, wrRise;
    assign rdFall = rdPrev_q && !rdS;
    assign rdRise = !rdPrev_q && rdS;
    assign wrFall = wrPrev_q && !wrS;
    assign wrRise = !wrPrev_q && wrS;

    // ------------------------------------------------------------
    // read side: receive buffer to bus
    // ------------------------------------------------------------
    ubf_phase_t rdPhase_q, rdPhase_d;
    logic [HOLD_W-1:0] rdHold_q, rdHold_d;
    logic [DATA_W-1:0] dataOut_q, dataOut_d;
    logic dataOe_q, dataOe_d, rxFlag_q, rxFlag_d;

    always_comb begin
        rdPhase_d = rdPhase_q;
        rdHold_d = rdHold_q;
        rxPop = 1'b0;
        if (syncMode_q) begin
            rdPhase_d = PH_IDLE;
            rdHold_d = HOLD_ZERO;
            // sync read: rise with strobe, enable and flag low; partner
            rxPop = clkRise && !rdS && !oeS && !rxFlag_q && rxOutValid;
        end else begin
            unique case (rdPhase_q)
                PH_IDLE: begin
                    // one byte per read strobe, taken at its falling edge
                    if (rdFall && !rxFlag_q && rxOutValid) begin
                        rxPop = 1'b1;
                        rdPhase_d = PH_STROBE;
                    end
                end
                PH_STROBE: begin
                    if (rdRise) begin
                        rdPhase_d = PH_HOLD;
                        rdHold_d = HOLD_LOAD;
                    end
                end
                PH_HOLD: begin
                    // flag recovery counted from the strobe's release
                    if (rdHold_q == HOLD_ZERO) begin
                        rdPhase_d = PH_IDLE;
                    end else begin
                        rdHold_d = rdHold_q - HOLD_ONE;
                    end
                end
                default: begin
                    rdPhase_d = PH_IDLE;
                end
            endcase
        end
        // bus byte changes only on a pop, so it stays put while the flag is high
        dataOut_d = rxPop ? rxHead : dataOut_q;
        // flag low means not empty; it goes high through each async cycle
        rxFlag_d = !((rdPhase_d == PH_IDLE) && rxOutValid);
        // async: drive while strobe low; sync: follow the output enable
        dataOe_d = syncMode_q ? oeS : rdS;
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rdPhase_q <= PH_IDLE;
            rdHold_q <= HOLD_ZERO;
            dataOut_q <= DATA_RESET;
            dataOe_q <= 1'b1;
            rxFlag_q <= 1'b1;
        end else begin
            rdPhase_q <= rdPhase_d;
            rdHold_q <= rdHold_d;
            dataOut_q <= dataOut_d;
            dataOe_q <= dataOe_d;
            rxFlag_q <= rxFlag_d;
        end
    end

    // ------------------------------------------------------------
    // write side: bus to transmit buffer
    // ------------------------------------------------------------
    ubf_phase_t wrPhase_q, wrPhase_d;
    logic [HOLD_W-1:0] wrHold_q, wrHold_d;
    logic txFlag_q, txFlag_d;

    always_comb begin
        wrPhase_d = wrPhase_q;
        wrHold_d = wrHold_q;
        txPush = 1'b0;
        txPushData = dataS;
        if (syncMode_q) begin
            wrPhase_d = PH_IDLE;
            wrHold_d = HOLD_ZERO;
            // sync write: rise with strobe and flag low; partner
            txPush = clkRise && !wrS && !txFlag_q && txInReady;
        end else begin
            unique case (wrPhase_q)
                PH_IDLE: begin
                    // a slot is reserved here; the byte is pushed later, at the strobe's release in PH_STROBE
                    if (wrFall && !txFlag_q && txInReady) begin
                        wrPhase_d = PH_STROBE;
                    end
                end
                PH_STROBE: begin
                    // byte latched as the write strobe is released
                    if (wrRise) begin
                        txPush = txInReady;
                        wrPhase_d = PH_HOLD;
                        wrHold_d = HOLD_LOAD;
                    end
                end
                PH_HOLD: begin
                    // flag recovery counted from the strobe's release
                    if (wrHold_q == HOLD_ZERO) begin
                        wrPhase_d = PH_IDLE;
                    end else begin
                        wrHold_d = wrHold_q - HOLD_ONE;
                    end
                end
                default: begin
                    wrPhase_d = PH_IDLE;
                end
            endcase
        end
        // low only with room; high through each async cycle
        txFlag_d = !((wrPhase_d == PH_IDLE) && txInReady);
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPhase_q <= PH_IDLE;
            wrHold_q <= HOLD_ZERO;
            txFlag_q <= 1'b1;
        end else begin
            wrPhase_q <= wrPhase_d;
            wrHold_q <= wrHold_d;
            txFlag_q <= txFlag_d;
        end
    end

    assign dataOut = dataOut_q;
    assign dataOe_n = dataOe_q;
    assign rx_data_avail_n = rxFlag_q;
    assign tx_space_flag_n = txFlag_q;
    assign sync_clock_out = sync_clock_out_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_n);

    sequence rdCycleEnd;
        !syncMode_q && rdPhase_q == PH_STROBE && rdRise;
    endsequence
    sequence wrCycleEnd;
        !syncMode_q && wrPhase_q == PH_STROBE && wrRise;
    endsequence
    sequence tenHigh(sig);
        sig [*8] ##1 sig ##1 sig;
    endsequence

    a_rx_empty_flag: assert property (!rxOutValid |=> rx_data_avail_n)
        else $error("receive flag low with empty buffer");
    a_tx_full_flag: assert property (!txInReady |=> tx_space_flag_n)
        else $error("transmit flag low with full buffer");
    a_rx_recovery: assert property (rdCycleEnd |=> tenHigh(rx_data_avail_n))
        else $error("receive flag recovered too early");
    a_tx_recovery: assert property (wrCycleEnd |=> tenHigh(tx_space_flag_n))
        else $error("transmit flag recovered too early");
    a_bus_data_hold: assert property (rx_data_avail_n |=> $stable(dataOut))
        else $error("bus byte changed while receive flag high");
    a_one_byte_read: assert property (rxPop && !syncMode_q |=> !rxPop [*8])
        else $error("second byte popped within one read cycle");
    a_clk_keeps_running: assert property (
        syncMode_q && $past(syncMode_q) && $stable(sync_clock_out)
        |=> (!syncMode_q || $changed(sync_clock_out)))
        else $error("clock output stalled in sync mode");
    a_async_no_clock: assert property (!syncMode_q |=> !sync_clock_out)
        else $error("clock output active outside sync mode");
    a_sync_write_edge: assert property (
        txPush && syncMode_q |-> !tx_space_flag_n && !sync_clock_out ##1 sync_clock_out)
        else $error("sync write away from a rising clock edge");
endmodule : ubf_port

// ==== logic/ubf_sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ubf_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stage_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q <= RST_VAL;
            stage_q <= RST_VAL;
        end else begin
            meta_q <= din;
            stage_q <= meta_q;
        end
    end

    assign dout = stage_q;
endmodule : ubf_sync2

// ==== tb/tb.sv ====
// self-checking bench for the byte fifo slave port
`timescale 1ns/100ps
module tb
    import ubf_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n, hostRxValid, hostTxReady, asyncOn, ok;
    logic [7:0] bitMode;
    logic [DATA_W-1:0] hostRxData, dataIn, dataOut, hostTxData, rdPrev, wv;
    logic dataOe_n, rdStrobe_n, wrStrobe_n, outEnable_n, rx_data_avail_n;
    logic tx_space_flag_n, sync_clock_out, hostRxReady, hostTxValid;
    logic [DATA_W-1:0] rxB[8], sB[6], txB[9];
    logic [DATA_W-1:0] rdSeen[$], txSeen[$];
    logic [31:0] seed = 32'h0000385c;
    // pin history, three deep, to match the two synchroniser flops plus the output register
    logic [2:0] rdH = 3'h7, oeH = 3'h7;
    int err_total = 0, total_checks = 0, cyc = 0, clkRises = 0, rxRun = 0, txRun = 0, n0;
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    always @(posedge sync_clock_out) clkRises++;
    ubf_port #(.DEPTH(FIFO_DEPTH)) i_ubf_port (.mclk(mclk), .rst_n(rst_n), .bitMode(bitMode),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n), .rdStrobe_n(rdStrobe_n),
        .wrStrobe_n(wrStrobe_n), .outEnable_n(outEnable_n), .rx_data_avail_n(rx_data_avail_n),
        .tx_space_flag_n(tx_space_flag_n), .sync_clock_out(sync_clock_out),
        .hostRxData(hostRxData), .hostRxValid(hostRxValid), .hostRxReady(hostRxReady),
        .hostTxData(hostTxData), .hostTxValid(hostTxValid), .hostTxReady(hostTxReady));
    ubf_partner i_ubf_partner (.dataOut(dataOut), .dataOe_n(dataOe_n),
        .rx_data_avail_n(rx_data_avail_n), .tx_space_flag_n(tx_space_flag_n), .dataIn(dataIn),
        .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n), .outEnable_n(outEnable_n));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // neighbouring bytes always differ so a new byte on the bus is seen as a change
    function automatic logic [DATA_W-1:0] mk_byte(input int i);
        logic [31:0] r;
        r = rnd();
        return {1'b1, r[3:0], 3'(i)};
    endfunction : mk_byte
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic push(input logic [DATA_W-1:0] v);
        hostRxData <= v;
        hostRxValid <= 1'b1;
        @(posedge mclk);
        while (hostRxReady !== 1'b1) @(posedge mclk);
    endtask : push
    // ------------------------------------------------------------
    // monitors and timeout
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20) check("oeFollow", dataOe_n, asyncOn ? rdH[2] : oeH[2]);
        rdH = {rdH[1:0], rdStrobe_n};
        oeH = {oeH[1:0], outEnable_n};
        if (dataOut !== rdPrev) begin
            rdSeen.push_back(dataOut);
            rdPrev = dataOut;
        end
        if (hostTxValid === 1'b1 && hostTxReady === 1'b1) txSeen.push_back(hostTxData);
        if (rx_data_avail_n === 1'b1) rxRun++;
        else begin
            if (asyncOn && rxRun > 0) check("rxRecovery", rxRun >= 10, 1);
            rxRun = 0;
        end
        if (tx_space_flag_n === 1'b1) txRun++;
        else begin
            if (asyncOn && txRun > 0) check("txRecovery", txRun >= 10, 1);
            txRun = 0;
        end
        if (cyc == 60000) begin
            err_total++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        // recovery runs are only judged once reset has settled, not across the reset span
        asyncOn = 1'b0;
        rdPrev = 8'h00;
        bitMode = 8'h00;
        hostRxData = 8'h00;
        hostRxValid = 1'b0;
        hostTxReady = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wv = 8'(rnd());
        if (wv === SYNC_MODE_CODE) wv = 8'h41;
        bitMode <= wv;
        repeat (12) @(posedge mclk);
        asyncOn = 1'b1;
        rdSeen.delete();
        for (int i = 0; i < 8; i++) rxB[i] = mk_byte(i);
        for (int i = 0; i < 8; i++) push(rxB[i]);
        hostRxData <= 8'h00;
        repeat (4) @(posedge mclk);
        check("rxFullReady", hostRxReady, 0);
        hostRxValid <= 1'b0;
        check("rxFlagData", rx_data_avail_n, 0);
        for (int i = 0; i < 8; i++) begin
            i_ubf_partner.async_cycle(1'b0, 8'h00, 1'b0, ok);
            check("rdAccepted", ok, 1);
        end
        // strobe while the flag is high must not move a byte
        i_ubf_partner.async_cycle(1'b0, 8'h00, 1'b1, ok);
        repeat (20) @(posedge mclk);
        check("rdCount", rdSeen.size(), 8);
        foreach (rxB[i]) check("rdByte", rdSeen[i], rxB[i]);
        check("rxFlagEmpty", rx_data_avail_n, 1);
        check("lastByteHeld", dataOut, rxB[7]);
        foreach (txB[i]) begin
            txB[i] = 8'(rnd());
            i_ubf_partner.async_cycle(1'b1, txB[i], 1'b0, ok);
            check("wrAccepted", ok, i < 8);
        end
        check("txFlagFull", tx_space_flag_n, 1);
        repeat (120) @(posedge mclk) hostTxReady <= 1'(rnd());
        hostTxReady <= 1'b1;
        repeat (20) @(posedge mclk);
        check("txCount", txSeen.size(), 8);
        check("txDrained", hostTxValid, 0);
        for (int i = 0; i < 8; i++) check("txByte", txSeen[i], txB[i]);
        check("txFlagRoom", tx_space_flag_n, 0);
        check("asyncNoClock", clkRises, 0);
        asyncOn = 1'b0;
        bitMode <= SYNC_MODE_CODE;
        repeat (20) @(posedge mclk);
        n0 = clkRises;
        repeat (1250) @(posedge mclk);
        check("syncRate", (clkRises - n0 >= 599) && (clkRises - n0 <= 601), 1);
        hostTxReady <= 1'b0;
        txSeen.delete();
        wv = 8'(rnd());
        i_ubf_partner.sync_stream(1'b0, wv);
        @(posedge mclk);
        check("syncTxFull", tx_space_flag_n, 1);
        hostTxReady <= 1'b1;
        repeat (30) @(posedge mclk);
        check("syncTxCount", txSeen.size(), 8);
        foreach (txSeen[i]) check("syncTxByte", txSeen[i], wv);
        for (int i = 0; i < 6; i++) sB[i] = mk_byte(i);
        for (int i = 0; i < 6; i++) push(sB[i]);
        hostRxValid <= 1'b0;
        repeat (10) @(posedge mclk);
        check("syncRxFlag", rx_data_avail_n, 0);
        i_ubf_partner.sync_stream(1'b1, 8'h00);
        repeat (20) @(posedge mclk);
        check("syncRdCount", rdSeen.size(), 14);
        foreach (sB[i]) check("syncRdByte", rdSeen[8 + i], sB[i]);
        check("syncLastHeld", dataOut, sB[5]);
        check("syncRxEmpty", rx_data_avail_n, 1);
        stop_test();
    end
endmodule : tb

// ==== tb/ubf_partner.sv ====
// behavioural far-side logic driving the byte port pins
`timescale 1ns/100ps
module ubf_partner
    import ubf_pkg::*;
(
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe_n,
    input wire logic rx_data_avail_n,
    input wire logic tx_space_flag_n,
    output logic [DATA_W-1:0] dataIn,
    output logic rdStrobe_n,
    output logic wrStrobe_n,
    output logic outEnable_n
);
    logic pclk;
    logic drv;
    logic [DATA_W-1:0] pData;
    // released bus shows the inverse so a stale byte never passes as fresh
    assign dataIn = !dataOe_n ? dataOut : (drv ? pData : ~pData);
    initial begin
        pclk = 1'b0;
        drv = 1'b0;
        pData = 8'h00;
        rdStrobe_n = 1'b1;
        wrStrobe_n = 1'b1;
        outEnable_n = 1'b1;
        #3;
        forever #32 pclk = ~pclk;
    end
    // wait for a low flag, give up after seven pclk edges, at most 448 ns
    task automatic wait_low(input logic useTx, output logic ok);
        int w;
        w = 0;
        while (((useTx ? tx_space_flag_n : rx_data_avail_n) !== 1'b0) && w < 7) begin
            @(posedge pclk);
            w++;
        end
        ok = (w < 7);
    endtask : wait_low
    // strobe low 128 ns, high 64 ns plus flag recovery
    task automatic async_cycle(input logic isWr, input logic [DATA_W-1:0] v,
                               input logic ignoreFlag, output logic ok);
        wait_low(isWr, ok);
        if (ignoreFlag) ok = 1'b1;
        if (ok) begin
            @(posedge pclk);
            pData <= v;
            drv <= isWr;
            @(posedge pclk);
            if (isWr) wrStrobe_n <= 1'b0;
            else rdStrobe_n <= 1'b0;
            repeat (2) @(posedge pclk);
            wrStrobe_n <= 1'b1;
            rdStrobe_n <= 1'b1;
            @(posedge pclk);
        end
    endtask : async_cycle
    task automatic sync_stream(input logic isRd, input logic [DATA_W-1:0] v);
        int hi;
        logic ok;
        @(posedge pclk);
        pData <= v;
        drv <= !isRd;
        // enable low before the read strobe
        outEnable_n <= !isRd;
        @(posedge pclk);
        // strobe once the space flag (write) or the data flag (read) is low, or after the wait gives up
        wait_low(!isRd, ok);
        // strobe held low for the whole stream
        if (isRd) rdStrobe_n <= 1'b0;
        else wrStrobe_n <= 1'b0;
        hi = 0;
        while (hi < 7) begin
            @(posedge pclk);
            hi = ((isRd ? rx_data_avail_n : tx_space_flag_n) !== 1'b0) ? hi + 1 : 0;
        end
        rdStrobe_n <= 1'b1;
        wrStrobe_n <= 1'b1;
        outEnable_n <= 1'b1;
    endtask : sync_stream
endmodule : ubf_partner
